// ===== hdl/ofc_config_regs.sv
/*
 Configuration register bank for the orientation and flat interrupts, fast
 offset compensation targets and the non-volatile memory programming enable,
 together with the small pieces of logic steered directly by those fields.
 Assumes a byte-wide register port decoded by the serial interface, and
 sensor data, event and request inputs synchronous to CLK.
 Reserved bits read back as zero whatever the host writes.
 Hold counts are parameters so a bench can shorten the timer.
*/
`timescale 1ns/10ps

// Contract
// RULE_01 - Remap bit 0 passes axes straight; 1 maps x<-y, y<-z, z<-x.
// RULE_02 - Up/down enable gates whether an up/down change raises orientation interrupt.
// RULE_03 - Six-bit orientation blocking angle field, 0 to 44.8 degrees.
// RULE_04 - Six-bit flat threshold angle in low bits; bits 7:6 reserved.
// RULE_05 - Flat interrupt only after stability for 0, 640, 1280 or 2560 ms.
// RULE_06 - Flat hysteresis in bits 2:0, hold code in bits 5:4, rest reserved.
// RULE_07 - Bit 6 of compensation register enables gyro compensation on all axes.
// RULE_08 - Per-axis accel target: 00 off, 01 +1g, 10 -1g, 11 0g.
// RULE_09 - Memory programming allowed only while config bit 1 is set.
// RULE_10 - Orientation hysteresis step is 62.5 mg in every range.
// RULE_11 - Host writes zeros to all reserved bits.
module ofc_config_regs #(
   parameter int HOLD1_CYC = ofc_pkg::HOLD_1_CYC,
   parameter int HOLD2_CYC = ofc_pkg::HOLD_2_CYC,
   parameter int HOLD3_CYC = ofc_pkg::HOLD_3_CYC
) (
   // Clock, reset and clock enable
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,

   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,

   // Axis data
   input wire ofc_pkg::ofc_axes_s SENSOR_AXES,
   output ofc_pkg::ofc_axes_s REG_AXES,

   // Orientation events
   input wire logic ORIENT_CHANGE,
   input wire logic UPDOWN_IND,
   output logic ORIENT_IRQ,
   input wire logic [3:0] ORIENT_HYST,
   output logic [13:0] ORIENT_HYST_DMG,

   // Flat events
   input wire logic FLAT_COND,
   output logic FLAT_IRQ,

   // Configuration to detection engines
   output ofc_pkg::ofc_cfg_s CFG,
   output logic [2:0] FOC_ACC_EN,
   output ofc_pkg::ofc_foc_target_e FOC_ACC_TARGET [3],

   // Memory programming
   input wire logic NVM_PROG_REQ,
   output logic NVM_PROG_GO
);

   // ==========================================================================
   // Register storage
   logic [7:0] orient_hi_r, orient_hi_nxt;
   logic [7:0] flat_angle_r, flat_angle_nxt;
   logic [7:0] flat_hold_r, flat_hold_nxt;
   logic [7:0] foc_r, foc_nxt;
   logic [7:0] sensor_cfg_r, sensor_cfg_nxt;

   // Read path
   logic [7:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;

   // Derived state
   ofc_pkg::ofc_axes_s axes_r, axes_nxt;
   ofc_pkg::ofc_cfg_s cfg_r, cfg_nxt;

   // Event state
   logic updown_prev_r, updown_prev_nxt;
   logic orient_irq_r, orient_irq_nxt;
   logic [13:0] hyst_dmg_r, hyst_dmg_nxt;
   logic nvm_go_r, nvm_go_nxt;
   logic [1:0] foc_code [3];

   // Field taps
   logic axis_remap_sel;
   logic updown_change_irq_en;
   logic [1:0] flat_hold_sel;
   logic nvm_prog_en;

   // Single fields, each read by one process or by the flat hold instance
   assign axis_remap_sel = orient_hi_r[ofc_pkg::BIT_REMAP];
   assign updown_change_irq_en = orient_hi_r[ofc_pkg::BIT_UD_EN];
   assign flat_hold_sel = flat_hold_r[ofc_pkg::HOLD_LSB +: 2]; // RULE_06
   assign nvm_prog_en = sensor_cfg_r[ofc_pkg::BIT_NVM_EN]; // RULE_09

   // ==========================================================================
   // Register writes
   // Next values: masked so reserved bits stay zero even if the host slips
   always_comb begin
      orient_hi_nxt = orient_hi_r;
      flat_angle_nxt = flat_angle_r;
      flat_hold_nxt = flat_hold_r;
      foc_nxt = foc_r;
      sensor_cfg_nxt = sensor_cfg_r;

      // Unmapped addresses change nothing
      if (CE && REG_WR) begin
         unique case (REG_ADDR)
            ofc_pkg::ADDR_ORIENT_HI:
               orient_hi_nxt = REG_WDATA & ofc_pkg::MSK_ORIENT_HI; // RULE_03
            ofc_pkg::ADDR_FLAT_ANGLE:
               flat_angle_nxt = REG_WDATA & ofc_pkg::MSK_FLAT_ANGLE; // RULE_04
            ofc_pkg::ADDR_FLAT_HOLD:
               flat_hold_nxt = REG_WDATA & ofc_pkg::MSK_FLAT_HOLD; // RULE_06
            ofc_pkg::ADDR_FOC:
               foc_nxt = REG_WDATA & ofc_pkg::MSK_FOC; // RULE_07
            ofc_pkg::ADDR_SENSOR_CFG:
               sensor_cfg_nxt = REG_WDATA & ofc_pkg::MSK_SENSOR_CFG; // RULE_09
            default: ;
         endcase
      end
   end

   // Storage registers
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         // Unknown reset bits come up zero
         orient_hi_r <= ofc_pkg::RST_ORIENT_HI;
         flat_angle_r <= ofc_pkg::RST_FLAT_ANGLE;
         flat_hold_r <= ofc_pkg::RST_FLAT_HOLD;
         foc_r <= ofc_pkg::RST_FOC;
         sensor_cfg_r <= ofc_pkg::RST_SENSOR_CFG;
      end else begin
         orient_hi_r <= orient_hi_nxt;
         flat_angle_r <= flat_angle_nxt;
         flat_hold_r <= flat_hold_nxt;
         foc_r <= foc_nxt;
         sensor_cfg_r <= sensor_cfg_nxt;
      end
   end

   // ==========================================================================
   // Register reads
   // Read data registered one cycle after the strobe; unmapped reads zero
   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = rvalid_r;

      // Valid follows the strobe; data holds to the next read
      if (CE) begin
         rvalid_nxt = REG_RD;
         if (REG_RD) begin
            unique case (REG_ADDR)
               ofc_pkg::ADDR_ORIENT_HI: rdata_nxt = orient_hi_r;
               ofc_pkg::ADDR_FLAT_ANGLE: rdata_nxt = flat_angle_r;
               ofc_pkg::ADDR_FLAT_HOLD: rdata_nxt = flat_hold_r;
               ofc_pkg::ADDR_FOC: rdata_nxt = foc_r;
               ofc_pkg::ADDR_SENSOR_CFG: rdata_nxt = sensor_cfg_r;
               default: rdata_nxt = ofc_pkg::RDATA_NONE;
            endcase
         end
      end
   end

   // Read registers
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rdata_r <= ofc_pkg::RDATA_NONE;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // Read port outputs
   assign REG_RDATA = rdata_r;
   assign REG_RVALID = rvalid_r;

   // ==========================================================================
   // Axis remap and configuration fan-out
   // Next values: remap costs one cycle of latency on the sample path
   always_comb begin
      axes_nxt = axes_r;
      cfg_nxt = cfg_r;

      if (CE) begin
         // Fixed rotation, not a general crossbar
         if (axis_remap_sel) begin
            axes_nxt.x = SENSOR_AXES.y; // RULE_01
            axes_nxt.y = SENSOR_AXES.z; // RULE_01
            axes_nxt.z = SENSOR_AXES.x; // RULE_01
         end else begin
            axes_nxt = SENSOR_AXES; // RULE_01
         end

         // Field copies lag the register by one cycle
         cfg_nxt.orient_block_theta = orient_hi_r[ofc_pkg::THETA_LSB +: 6]; // RULE_03
         cfg_nxt.flat_theta = flat_angle_r[ofc_pkg::THETA_LSB +: 6]; // RULE_04
         cfg_nxt.flat_hysteresis = flat_hold_r[ofc_pkg::HYST_LSB +: 3]; // RULE_06
         cfg_nxt.gyr_foc_en = foc_r[ofc_pkg::BIT_GYR_FOC]; // RULE_07
      end
   end

   // Remap and configuration registers
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         axes_r <= '0;
         cfg_r <= '0;
      end else begin
         axes_r <= axes_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // Remap and configuration outputs
   assign REG_AXES = axes_r;
   assign CFG = cfg_r;

   // ==========================================================================
   // Orientation interrupt, hysteresis scaling and programming gate
   // Next values: a masked up/down flip is dropped, other changes pass
   always_comb begin
      updown_prev_nxt = updown_prev_r;
      orient_irq_nxt = orient_irq_r;
      hyst_dmg_nxt = hyst_dmg_r;
      nvm_go_nxt = nvm_go_r;

      if (CE) begin
         updown_prev_nxt = UPDOWN_IND;
         // Direct changes always pass, flips only when unmasked
         orient_irq_nxt = ORIENT_CHANGE
            | (updown_change_irq_en && (UPDOWN_IND != updown_prev_r)); // RULE_02
         // No range input on purpose: the step must not follow the g-range
         hyst_dmg_nxt = 14'(ORIENT_HYST) * 14'(ofc_pkg::ORIENT_HYST_STEP_DMG); // RULE_10

         // Level gate: a held request follows the enable bit
         nvm_go_nxt = NVM_PROG_REQ && nvm_prog_en; // RULE_09
      end
   end

   // Event registers
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         // Up/down history starts low
         updown_prev_r <= 1'b0;
         orient_irq_r <= 1'b0;
         hyst_dmg_r <= '0;
         nvm_go_r <= 1'b0;
      end else begin
         updown_prev_r <= updown_prev_nxt;
         orient_irq_r <= orient_irq_nxt;
         hyst_dmg_r <= hyst_dmg_nxt;
         nvm_go_r <= nvm_go_nxt;
      end
   end

   // Event and gate outputs
   assign ORIENT_IRQ = orient_irq_r;
   assign ORIENT_HYST_DMG = hyst_dmg_r;
   assign NVM_PROG_GO = nvm_go_r;

   // ==========================================================================
   // Flat hold timer
   // Hold code is read live during a wait
   ofc_flat_hold #(
      .HOLD1_CYC(HOLD1_CYC),
      .HOLD2_CYC(HOLD2_CYC),
      .HOLD3_CYC(HOLD3_CYC)
   ) u_flat_hold (
      .clk(CLK),
      .reset(RESET),
      .ce(CE),
      .hold_sel(flat_hold_sel),
      .flat_cond(FLAT_COND),
      .irq(FLAT_IRQ)
   );

   // ==========================================================================
   // Accelerometer compensation target decoders, x then y then z
   assign foc_code[0] = foc_r[ofc_pkg::FOC_X_LSB +: 2]; // RULE_08
   assign foc_code[1] = foc_r[ofc_pkg::FOC_Y_LSB +: 2]; // RULE_08
   assign foc_code[2] = foc_r[ofc_pkg::FOC_Z_LSB +: 2]; // RULE_08

   // One decoder per axis keeps code and enable aligned
   for (genvar g = 0; g < ofc_pkg::NUM_ACC_AXES; g++) begin : g_foc
      ofc_foc_axis u_axis (
         .clk(CLK),
         .reset(RESET),
         .ce(CE),
         .code(foc_code[g]),
         .en(FOC_ACC_EN[g]),
         .target(FOC_ACC_TARGET[g])
      );
   end

endmodule : ofc_config_regs

// ===== hdl/ofc_pkg.sv
/*
 Shared constants and types for the orientation, flat, offset compensation and
 programming-enable configuration bank.
 Assumes a single 50 MHz clock domain and byte-wide register access.
*/
package ofc_pkg;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0] ADDR_ORIENT_HI = 8'h66;
   localparam logic [7:0] ADDR_FLAT_ANGLE = 8'h67;
   localparam logic [7:0] ADDR_FLAT_HOLD = 8'h68;
   localparam logic [7:0] ADDR_FOC = 8'h69;
   localparam logic [7:0] ADDR_SENSOR_CFG = 8'h6A;

   // ==========================================================================
   // Reset values (unknown bits taken as zero)
   localparam logic [7:0] RST_ORIENT_HI = 8'h48;
   localparam logic [7:0] RST_FLAT_ANGLE = 8'h08;
   localparam logic [7:0] RST_FLAT_HOLD = 8'h11;
   localparam logic [7:0] RST_FOC = 8'h00;
   localparam logic [7:0] RST_SENSOR_CFG = 8'h00;

   // ==========================================================================
   // Writable bits; reserved bits are held at zero
   localparam logic [7:0] MSK_ORIENT_HI = 8'hFF;
   localparam logic [7:0] MSK_FLAT_ANGLE = 8'h3F;
   localparam logic [7:0] MSK_FLAT_HOLD = 8'h37;
   localparam logic [7:0] MSK_FOC = 8'h7F;
   localparam logic [7:0] MSK_SENSOR_CFG = 8'h02;
   localparam logic [7:0] RDATA_NONE = 8'h00;

   // ==========================================================================
   // Field positions
   localparam int BIT_REMAP = 7;
   localparam int BIT_UD_EN = 6;
   localparam int THETA_LSB = 0;
   localparam int HOLD_LSB = 4;
   localparam int HYST_LSB = 0;
   localparam int BIT_GYR_FOC = 6;
   localparam int FOC_X_LSB = 4;
   localparam int FOC_Y_LSB = 2;
   localparam int FOC_Z_LSB = 0;
   localparam int BIT_NVM_EN = 1;
   localparam int NUM_ACC_AXES = 3;

   // ==========================================================================
   // Timing
   localparam int CLK_FREQ_HZ = 50_000_000;
   localparam int CYC_PER_MS = CLK_FREQ_HZ / 1000;
   localparam int HOLD_1_MS = 640;
   localparam int HOLD_2_MS = 1280;
   localparam int HOLD_3_MS = 2560;
   localparam int HOLD_1_CYC = HOLD_1_MS * CYC_PER_MS;
   localparam int HOLD_2_CYC = HOLD_2_MS * CYC_PER_MS;
   localparam int HOLD_3_CYC = HOLD_3_MS * CYC_PER_MS;
   localparam int HOLD_CNT_W = 28;

   // Orientation hysteresis step in tenths of a milli-g, range independent
   localparam logic [9:0] ORIENT_HYST_STEP_DMG = 10'h271;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      FOC_OFF = 2'h0,
      FOC_PLUS_1G = 2'h1,
      FOC_MINUS_1G = 2'h2,
      FOC_ZERO_G = 2'h3
   } ofc_foc_target_e;

   typedef enum logic [1:0] {
      FLAT_IDLE = 2'h0,
      FLAT_WAIT = 2'h1,
      FLAT_DONE = 2'h3
   } ofc_flat_state_e;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } ofc_axes_s;

   typedef struct packed {
      logic [5:0] orient_block_theta;
      logic [5:0] flat_theta;
      logic [2:0] flat_hysteresis;
      logic gyr_foc_en;
   } ofc_cfg_s;

endpackage : ofc_pkg

// ===== hdl/ofc_foc_axis.sv
/*
 Decoder of one accelerometer axis offset compensation target code.
 Assumes the code comes from a register in the same clock domain.
*/
`timescale 1ns/10ps
module ofc_foc_axis (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Code in
   input wire logic [1:0] code,
   // Decoded target
   output logic en,
   output ofc_pkg::ofc_foc_target_e target
);

   logic en_nxt;
   logic en_r;
   ofc_pkg::ofc_foc_target_e target_nxt;
   ofc_pkg::ofc_foc_target_e target_r;

   // ==========================================================================
   // Decode
   // Next values: zero code disables the axis
   always_comb begin
      target_nxt = target_r;
      en_nxt = en_r;
      if (ce) begin
         target_nxt = ofc_pkg::ofc_foc_target_e'(code); // RULE_08
         en_nxt = (code != ofc_pkg::FOC_OFF); // RULE_08
      end
   end

   // Registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         target_r <= ofc_pkg::FOC_OFF;
         en_r <= 1'b0;
      end else begin
         target_r <= target_nxt;
         en_r <= en_nxt;
      end
   end

   assign en = en_r;
   assign target = target_r;

endmodule : ofc_foc_axis

// ===== hdl/ofc_flat_hold.sv
/*
 Flat hold timer: pulses once when the flat indication has stayed unchanged
 for the selected hold time after a change.
 Assumes flat_cond is synchronous to clk.
*/
`timescale 1ns/10ps
module ofc_flat_hold #(
   parameter int HOLD1_CYC = ofc_pkg::HOLD_1_CYC,
   parameter int HOLD2_CYC = ofc_pkg::HOLD_2_CYC,
   parameter int HOLD3_CYC = ofc_pkg::HOLD_3_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Control
   input wire logic [1:0] hold_sel,
   input wire logic flat_cond,
   // Event
   output logic irq
);

   localparam int CW = ofc_pkg::HOLD_CNT_W;

   ofc_pkg::ofc_flat_state_e state_r, state_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt, limit;
   logic prev_r, prev_nxt, irq_r, irq_nxt;

   // ==========================================================================
   // Hold limit per code; code zero fires one cycle after the change
   always_comb begin
      unique case (hold_sel)
         2'h0: limit = '0;
         2'h1: limit = CW'(HOLD1_CYC);
         2'h2: limit = CW'(HOLD2_CYC);
         2'h3: limit = CW'(HOLD3_CYC);
      endcase
   end

   // Next state: any change restarts the wait so only stable values fire
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      prev_nxt = prev_r;
      irq_nxt = irq_r;
      if (ce) begin
         irq_nxt = 1'b0;
         prev_nxt = flat_cond;
         if (flat_cond != prev_r) begin
            state_nxt = ofc_pkg::FLAT_WAIT; // RULE_05
            cnt_nxt = '0;
         end else begin
            unique case (state_r)
               ofc_pkg::FLAT_IDLE: state_nxt = ofc_pkg::FLAT_IDLE;
               ofc_pkg::FLAT_WAIT: begin
                  if (cnt_r >= limit) begin
                     irq_nxt = 1'b1; // RULE_05
                     state_nxt = ofc_pkg::FLAT_DONE;
                  end else begin
                     cnt_nxt = cnt_r + CW'(1);
                  end
               end
               ofc_pkg::FLAT_DONE: state_nxt = ofc_pkg::FLAT_DONE;
               default: state_nxt = ofc_pkg::FLAT_IDLE;
            endcase
         end
      end
   end

   // Registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= ofc_pkg::FLAT_IDLE;
         cnt_r <= '0;
         prev_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         prev_r <= prev_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign irq = irq_r;

endmodule : ofc_flat_hold

// ===== verification/ofc_cfg_asserts.sv
/*
 Port assertions for ofc_config_regs, bound to every instance.
 Assumes one CLK domain and the register reset values of the bank.
*/
`timescale 1ns/10ps
module ofc_cfg_asserts (
   // Clock, reset, enable
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   // Register writes
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   // Data and events
   input wire ofc_pkg::ofc_axes_s SENSOR_AXES,
   input wire ofc_pkg::ofc_axes_s REG_AXES,
   input wire logic ORIENT_CHANGE,
   input wire logic UPDOWN_IND,
   input wire logic ORIENT_IRQ,
   input wire logic [3:0] ORIENT_HYST,
   input wire logic [13:0] ORIENT_HYST_DMG,
   input wire logic FLAT_COND,
   input wire logic FLAT_IRQ,
   input wire ofc_pkg::ofc_cfg_s CFG,
   input wire logic [2:0] FOC_ACC_EN,
   input wire ofc_pkg::ofc_foc_target_e FOC_ACC_TARGET [3],
   input wire logic NVM_PROG_REQ,
   input wire logic NVM_PROG_GO
);
   // ====================
   // Shadow: {remap, updown enable, program enable, hold code zero}
   logic [3:0] sh_r;
   logic [3:0] sh_nxt;

   // Tracks writes so no register read is needed
   always_comb begin
      sh_nxt = sh_r;
      if (CE && REG_WR && REG_ADDR == 8'h66) sh_nxt[3:2] = REG_WDATA[7:6];
      if (CE && REG_WR && REG_ADDR == 8'h6A) sh_nxt[1] = REG_WDATA[1];
      if (CE && REG_WR && REG_ADDR == 8'h68) sh_nxt[0] = REG_WDATA[5:4] == 2'h0;
   end

   // Reset image of 0x66, 0x68 and 0x6A
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) sh_r <= 4'h4;
      else sh_r <= sh_nxt;
   end

   // ====================
   // Properties
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);

   // Write taken, then one enabled cycle for the output stage
   sequence s_wr(logic [7:0] a);
      CE && REG_WR && REG_ADDR == a ##1 CE;
   endsequence

   // Flat change under a zero hold code, then one stable cycle
   sequence s_flat_chg;
      CE && !$past(RESET) && sh_r[0] && FLAT_COND != $past(FLAT_COND)
         ##1 CE && $stable(FLAT_COND);
   endsequence

   AST_REMAP:
   assert property (CE |=> REG_AXES == ($past(sh_r[3]) ? {$past(SENSOR_AXES.y),
      $past(SENSOR_AXES.z), $past(SENSOR_AXES.x)} : $past(SENSOR_AXES)))
      else $error("remapped axes wrong");
   AST_UD_IRQ:
   assert property (CE && $past(CE) && !$past(RESET) |=> ORIENT_IRQ == ($past(ORIENT_CHANGE)
      || ($past(sh_r[2]) && $past(UPDOWN_IND) != $past(UPDOWN_IND, 2))))
      else $error("orientation interrupt wrong");
   AST_ORIENT_THETA:
   assert property (s_wr(8'h66) |=> CFG.orient_block_theta == $past(REG_WDATA[5:0], 2))
      else $error("blocking angle wrong");
   AST_FLAT_THETA:
   assert property (s_wr(8'h67) |=> CFG.flat_theta == $past(REG_WDATA[5:0], 2))
      else $error("flat angle wrong");
   AST_FLAT_ZERO:
   assert property (s_flat_chg |=> FLAT_IRQ)
      else $error("flat interrupt late");
   AST_FLAT_ONCE:
   assert property (FLAT_IRQ && CE |=> !FLAT_IRQ)
      else $error("flat interrupt too long");
   AST_FLAT_HYST:
   assert property (s_wr(8'h68) |=> CFG.flat_hysteresis == $past(REG_WDATA[2:0], 2))
      else $error("flat hysteresis wrong");
   AST_GYR:
   assert property (s_wr(8'h69) |=> CFG.gyr_foc_en == $past(REG_WDATA[6], 2))
      else $error("gyro enable wrong");
   AST_FOC_X:
   assert property (s_wr(8'h69) |=> FOC_ACC_TARGET[0] == $past(REG_WDATA[5:4], 2)
      && FOC_ACC_EN[0] == ($past(REG_WDATA[5:4], 2) != 2'h0))
      else $error("x target wrong");
   AST_NVM_GO:
   assert property (CE |=> NVM_PROG_GO == ($past(NVM_PROG_REQ) && $past(sh_r[1])))
      else $error("programming gate wrong");
   AST_HYST:
   assert property (CE |=> ORIENT_HYST_DMG == {10'h000, $past(ORIENT_HYST)} * 14'h271)
      else $error("hysteresis scale wrong");
endmodule : ofc_cfg_asserts

bind ofc_config_regs ofc_cfg_asserts u_asserts (
   .CLK(CLK), .RESET(RESET), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .REG_WDATA(REG_WDATA), .SENSOR_AXES(SENSOR_AXES), .REG_AXES(REG_AXES),
   .ORIENT_CHANGE(ORIENT_CHANGE), .UPDOWN_IND(UPDOWN_IND), .ORIENT_IRQ(ORIENT_IRQ),
   .ORIENT_HYST(ORIENT_HYST), .ORIENT_HYST_DMG(ORIENT_HYST_DMG), .FLAT_COND(FLAT_COND),
   .FLAT_IRQ(FLAT_IRQ), .CFG(CFG), .FOC_ACC_EN(FOC_ACC_EN),
   .FOC_ACC_TARGET(FOC_ACC_TARGET), .NVM_PROG_REQ(NVM_PROG_REQ), .NVM_PROG_GO(NVM_PROG_GO)
);

// ===== verification/ofc_host_model.sv
/*
 Host model of the byte register port: single reads and writes.
 Assumes the bench calls its tasks; it drives on falling CLK.
*/
`timescale 1ns/10ps
module ofc_host_model (
   // Clock
   input wire logic CLK,
   // Register port
   output logic [7:0] REG_ADDR,
   output logic REG_WR,
   output logic [7:0] REG_WDATA,
   output logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_RVALID
);
   // Idle port
   initial begin
      REG_ADDR = 8'h00;
      REG_WR = 1'b0;
      REG_WDATA = 8'h00;
      REG_RD = 1'b0;
   end

   // Writable bits per register
   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         8'h67: wmask = 8'h3F;
         8'h68: wmask = 8'h37;
         8'h69: wmask = 8'h7F;
         8'h6A: wmask = 8'h02;
         default: wmask = 8'hFF;
      endcase
   endfunction

   // One write strobe; raw leaves reserved bits as given
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
      @(negedge CLK);
      REG_ADDR = a;
      REG_WDATA = raw ? d : d & wmask(a);
      REG_WR = 1'b1;
      @(negedge CLK);
      REG_WR = 1'b0;
      REG_ADDR = ~REG_ADDR; // Released lines must not look valid
      REG_WDATA = ~REG_WDATA;
   endtask : wr

   // One read strobe; data and valid taken a cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge CLK);
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(negedge CLK);
      REG_RD = 1'b0;
      REG_ADDR = ~REG_ADDR;
      ok = REG_RVALID;
      d = REG_RDATA;
   endtask : rd
endmodule : ofc_host_model

// ===== verification/ofc_config_regs_tb.sv
/*
 Self-checking bench for ofc_config_regs: register map, decoded outputs
 and event timing. Assumes short hold counts of 5, 10 and 20 cycles.
*/
`timescale 1ns/10ps
module ofc_config_regs_tb;
   // ====================
   // Signals
   logic clk, rst, ce, o_chg, ud, flat, req, wr, rdst, rvalid, oirq, firq, go, ok;
   logic [3:0] hyst;
   logic [7:0] addr, wdata, rdata, d;
   logic [13:0] dmg;
   logic [2:0] fen;
   ofc_pkg::ofc_axes_s sax, rax;
   ofc_pkg::ofc_cfg_s cfg;
   ofc_pkg::ofc_foc_target_e tgt [3];
   int err_count, n_checks, k, n, no;
   localparam logic [7:0] RA [5] = '{8'h66, 8'h67, 8'h68, 8'h69, 8'h6A};
   localparam logic [7:0] RV [5] = '{8'h48, 8'h08, 8'h11, 8'h00, 8'h00};
   localparam logic [7:0] RM [5] = '{8'hFF, 8'h3F, 8'h37, 8'h7F, 8'h02};
   localparam int HC [4] = '{0, 5, 10, 20};

   ofc_config_regs #(.HOLD1_CYC(5), .HOLD2_CYC(10), .HOLD3_CYC(20)) uut (
      .CLK(clk), .RESET(rst), .CE(ce), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
      .REG_RD(rdst), .REG_RDATA(rdata), .REG_RVALID(rvalid), .SENSOR_AXES(sax),
      .REG_AXES(rax), .ORIENT_CHANGE(o_chg), .UPDOWN_IND(ud), .ORIENT_IRQ(oirq),
      .ORIENT_HYST(hyst), .ORIENT_HYST_DMG(dmg), .FLAT_COND(flat), .FLAT_IRQ(firq),
      .CFG(cfg), .FOC_ACC_EN(fen), .FOC_ACC_TARGET(tgt), .NVM_PROG_REQ(req),
      .NVM_PROG_GO(go));
   ofc_host_model host (.CLK(clk), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
      .REG_RD(rdst), .REG_RDATA(rdata), .REG_RVALID(rvalid));

   // Clock and orientation pulse counter
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (oirq === 1'b1) no++;

   // ====================
   // Checking
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d, ok);
      chk({ok, d}, {1'b1, e}, "read");
   endtask : rchk

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test

   // Watchdog well beyond the couple of hundred cycles needed
   initial begin
      #400000;
      err_count++;
      finish_test();
   end

   // ====================
   // Tests
   initial begin
      rst = 1'b1; ce = 1'b1; o_chg = 1'b0; ud = 1'b0; flat = 1'b0; req = 1'b0;
      hyst = 4'h0;
      sax = {16'h1111, 16'h2222, 16'h3333};
      repeat (8) @(negedge clk);
      rst = 1'b0;
      // Reset image, then all ones to find reserved bits
      for (k = 0; k < 5; k++) rchk(RA[k], RV[k]);
      for (k = 0; k < 5; k++) begin
         host.wr(RA[k], 8'hFF, 1'b1);
         rchk(RA[k], RM[k]);
      end
      host.wr(8'h6B, 8'hFF, 1'b1);
      rchk(8'h6B, 8'h00);
      // Write with clock enable low is dropped
      @(negedge clk);
      ce = 1'b0;
      host.wr(8'h67, 8'h00, 1'b0);
      ce = 1'b1;
      rchk(8'h67, 8'h3F);
      chk(rax, {sax.y, sax.z, sax.x}, "remap on");
      chk(cfg, {6'h3F, 6'h3F, 3'h7, 1'b1}, "fields full");
      req = 1'b1;
      @(negedge clk);
      chk(go, 1'b1, "prog on");
      host.wr(8'h6A, 8'h00, 1'b0);
      @(negedge clk);
      chk(go, 1'b0, "prog off");
      host.wr(8'h66, 8'h40, 1'b0);
      @(negedge clk);
      chk({rax, cfg.orient_block_theta}, {sax, 6'h00}, "remap off");
      // Up/down change counts only while enabled
      for (k = 1; k >= 0; k--) begin
         no = 0;
         ud = ~ud;
         repeat (4) @(negedge clk);
         chk(no, k, "updown irq");
         host.wr(8'h66, 8'h00, 1'b0);
      end
      no = 0;
      o_chg = 1'b1;
      @(negedge clk);
      o_chg = 1'b0;
      repeat (2) @(negedge clk);
      chk(no, 1, "change irq");
      // Flat hold for every code, cycles from the change
      for (k = 0; k < 4; k++) begin
         host.wr(8'h68, {2'h0, k[1:0], 4'h1}, 1'b0);
         flat = ~flat;
         n = 0;
         while (firq !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
         end
         chk(n, HC[k] + 2, "flat hold");
      end
      // Every compensation target code on all axes
      for (k = 0; k < 4; k++) begin
         // Distinct codes per axis so swapped fields show up
         host.wr(8'h69, {1'b0, k[0], k[1:0], 2'(k + 1), 2'(k + 2)}, 1'b0);
         repeat (2) @(negedge clk);
         chk({cfg.gyr_foc_en, fen, tgt[0], tgt[1], tgt[2]}, {k[0], 2'(k + 2) != 2'h0,
            2'(k + 1) != 2'h0, k[1:0] != 2'h0, k[1:0], 2'(k + 1), 2'(k + 2)},
            "foc");
      end
      // Hysteresis scale over all codes
      for (k = 0; k < 16; k++) begin
         hyst = k[3:0];
         @(negedge clk);
         chk(dmg, k * 625, "hyst scale");
      end
      finish_test();
   end
endmodule : ofc_config_regs_tb
